// ---- qbgp_pkg.sv ----
// Package with register map, field layout and reset values for the quad-bit GPIO ports
package qbgp_pkg;
   localparam int QBGP_PINS = 4;
   localparam logic [7:0] QBGP_OFS_P8_LATCH = 8'h00;
   localparam logic [7:0] QBGP_OFS_P8_DIR = 8'h04;
   localparam logic [7:0] QBGP_OFS_P8_PULL = 8'h08;
   localparam logic [7:0] QBGP_OFS_PE_LATCH = 8'h0C;
   localparam logic [7:0] QBGP_OFS_PE_DIR = 8'h10;
   localparam logic [7:0] QBGP_OFS_PE_PULL = 8'h14;
   localparam logic [7:0] QBGP_OFS_CFG = 8'h18;
   localparam logic [7:0] QBGP_OFS_RMW_VIEW = 8'h20;
   localparam int QBGP_CFG_SPL_BIT = 0;
   localparam int QBGP_CFG_TRGSEL_BIT = 1;
   localparam logic [3:0] QBGP_RST_LATCH = 4'h0;
   localparam logic [3:0] QBGP_RST_DIR = 4'h0;
   localparam logic [3:0] QBGP_RST_PULL = 4'h0;
   localparam logic QBGP_RST_SPL = 1'b0;
   localparam logic QBGP_RST_TRGSEL = 1'b0;
   localparam logic [2:0] QBGP_IDX_P8_LATCH = 3'h0;
   localparam logic [2:0] QBGP_IDX_P8_DIR = 3'h1;
   localparam logic [2:0] QBGP_IDX_P8_PULL = 3'h2;
   localparam logic [2:0] QBGP_IDX_PE_LATCH = 3'h3;
   localparam logic [2:0] QBGP_IDX_PE_DIR = 3'h4;
   localparam logic [2:0] QBGP_IDX_PE_PULL = 3'h5;
   localparam logic [2:0] QBGP_IDX_CFG = 3'h6;
   localparam logic [2:0] QBGP_IDX_NONE = 3'h7;
endpackage

// ---- qbgp_ports.sv ----
// Two 4-bit GPIO ports with AHB-Lite register access, standby forcing and peripheral routing
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module qbgp_ports
   import qbgp_pkg::*;
#(
   parameter int NPINS = QBGP_PINS
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic standby_stop_watch,
   input wire logic ext_irq_ctrl_ch0_en,
   input wire logic irq_pin_select_ctrl_en,
   input wire logic [NPINS-1:0] porte_irq_en,
   input wire logic port1_pin3,
   input wire logic [NPINS-1:0] port8_pin_in,
   output logic [NPINS-1:0] port8_pin_out,
   output logic [NPINS-1:0] port8_pin_oe,
   output logic [NPINS-1:0] port8_pullup_on,
   input wire logic [NPINS-1:0] porte_pin_in,
   output logic [NPINS-1:0] porte_pin_out,
   output logic [NPINS-1:0] porte_pin_oe,
   output logic [NPINS-1:0] porte_pullup_on,
   output logic [NPINS-1:0] port8_in_path,
   output logic [NPINS-1:0] porte_in_path,
   output logic ext_irq_line_a,
   output logic ext_irq_line_b,
   output logic ext_irq_line_c,
   output logic ext_irq_line_d,
   output logic pwm_timer_trigger_in,
   output logic adc_trigger_in
);

   typedef struct packed {
      logic wr_pend;
      logic [2:0] wr_idx;
      logic [NPINS-1:0] p8_lat;
      logic [NPINS-1:0] p8_dir;
      logic [NPINS-1:0] p8_pul;
      logic [NPINS-1:0] pe_lat;
      logic [NPINS-1:0] pe_dir;
      logic [NPINS-1:0] pe_pul;
      logic standby_pin_state_bit;
      logic trgsel;
      logic [NPINS-1:0] rdata;
      logic ready;
      logic [NPINS-1:0] p8_out;
      logic [NPINS-1:0] p8_oe;
      logic [NPINS-1:0] p8_pu;
      logic [NPINS-1:0] pe_out;
      logic [NPINS-1:0] pe_oe;
      logic [NPINS-1:0] pe_pu;
      logic [NPINS-1:0] p8_in;
      logic [NPINS-1:0] pe_in;
      logic [NPINS-1:0] irq;
      logic trig;
   } qbgp_state_s;

   qbgp_state_s st_ff;
   qbgp_state_s nxt_st;

   // Byte offset to register index; the READ_MODIFY_WRITE_ACCESS view aliases all seven registers
   function automatic logic [2:0] reg_idx(input logic [7:0] ofs);
      logic [2:0] idx;
      idx = QBGP_IDX_NONE;
      unique case (ofs)
         QBGP_OFS_P8_LATCH: idx = QBGP_IDX_P8_LATCH;
         QBGP_OFS_P8_DIR: idx = QBGP_IDX_P8_DIR;
         QBGP_OFS_P8_PULL: idx = QBGP_IDX_P8_PULL;
         QBGP_OFS_PE_LATCH: idx = QBGP_IDX_PE_LATCH;
         QBGP_OFS_PE_DIR: idx = QBGP_IDX_PE_DIR;
         QBGP_OFS_PE_PULL: idx = QBGP_IDX_PE_PULL;
         QBGP_OFS_CFG: idx = QBGP_IDX_CFG;
         default: idx = QBGP_IDX_NONE;
      endcase
      return idx;
   endfunction

   // Normal reads mix latch and pin per direction bit; READ_MODIFY_WRITE_ACCESS reads see only the latch
   function automatic logic [NPINS-1:0] port_read(
      input logic read_modify_write_access,
      input logic [NPINS-1:0] dir,
      input logic [NPINS-1:0] lat,
      input logic [NPINS-1:0] pin
   );
      logic [NPINS-1:0] val;
      val = (dir & lat) | (~dir & pin);
      if (read_modify_write_access) begin
         val = lat;
      end
      return val;
   endfunction

   logic addr_phase;
   logic rmw_view;
   logic [2:0] aidx;
   logic force_hiz;
   logic [NPINS-1:0] p8_keep;
   logic [NPINS-1:0] p8_blk;
   logic [NPINS-1:0] pe_blk;

   assign addr_phase = hsel & hready & htrans[1];
   assign rmw_view = (haddr[7:0] & QBGP_OFS_RMW_VIEW) != 8'h00;
   assign aidx = reg_idx(haddr[7:0] & ~QBGP_OFS_RMW_VIEW);
   assign force_hiz = st_ff.standby_pin_state_bit & standby_stop_watch;
   assign p8_keep = {ext_irq_ctrl_ch0_en & irq_pin_select_ctrl_en, {(NPINS-1){1'b0}}};

   // Input path gating; blocked inputs sit low to avoid floating-input leakage
   assign p8_blk = (force_hiz ? p8_keep : {NPINS{1'b1}}) & port8_pin_in;
   assign pe_blk = (force_hiz ? porte_irq_en : {NPINS{1'b1}}) & porte_pin_in;

   // Next-state logic: bus decode, register writes, pin drive and routing
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ready = 1'b1;
      nxt_st.wr_pend = addr_phase & hwrite;
      nxt_st.wr_idx = aidx;
      // Data phase write lands in low nibble only
      if (st_ff.wr_pend) begin
         unique case (st_ff.wr_idx)
            QBGP_IDX_P8_LATCH: nxt_st.p8_lat = hwdata[NPINS-1:0];
            QBGP_IDX_P8_DIR: nxt_st.p8_dir = hwdata[NPINS-1:0];
            QBGP_IDX_P8_PULL: nxt_st.p8_pul = hwdata[NPINS-1:0];
            QBGP_IDX_PE_LATCH: nxt_st.pe_lat = hwdata[NPINS-1:0];
            QBGP_IDX_PE_DIR: nxt_st.pe_dir = hwdata[NPINS-1:0];
            QBGP_IDX_PE_PULL: nxt_st.pe_pul = hwdata[NPINS-1:0];
            QBGP_IDX_CFG: begin
               nxt_st.standby_pin_state_bit = hwdata[QBGP_CFG_SPL_BIT];
               nxt_st.trgsel = hwdata[QBGP_CFG_TRGSEL_BIT];
            end
            default: nxt_st.standby_pin_state_bit = st_ff.standby_pin_state_bit;
         endcase
      end
      // Read data captured in the address phase so it stands in the data phase
      // Values come from nxt_st so a read right behind a write sees the new value
      if (addr_phase & ~hwrite) begin
         unique case (aidx)
            QBGP_IDX_P8_LATCH: nxt_st.rdata =
               port_read(rmw_view, nxt_st.p8_dir, nxt_st.p8_lat, p8_blk);
            QBGP_IDX_P8_DIR: nxt_st.rdata = nxt_st.p8_dir;
            QBGP_IDX_P8_PULL: nxt_st.rdata = nxt_st.p8_pul;
            QBGP_IDX_PE_LATCH: nxt_st.rdata =
               port_read(rmw_view, nxt_st.pe_dir, nxt_st.pe_lat, pe_blk);
            QBGP_IDX_PE_DIR: nxt_st.rdata = nxt_st.pe_dir;
            QBGP_IDX_PE_PULL: nxt_st.rdata = nxt_st.pe_pul;
            QBGP_IDX_CFG: nxt_st.rdata = {{(NPINS-2){1'b0}}, nxt_st.trgsel, nxt_st.standby_pin_state_bit};
            default: nxt_st.rdata = '0;
         endcase
      end
      // Pin drive from the next latch so a write reaches the pin with the store
      nxt_st.p8_out = nxt_st.p8_lat;
      nxt_st.pe_out = nxt_st.pe_lat;
      nxt_st.p8_oe = force_hiz ? '0 : nxt_st.p8_dir;
      nxt_st.pe_oe = force_hiz ? '0 : nxt_st.pe_dir;
      // Pull-up off while driving low, and off while the pin is forced
      nxt_st.p8_pu = force_hiz ? '0 : nxt_st.p8_pul & ~(nxt_st.p8_dir & ~nxt_st.p8_lat);
      nxt_st.pe_pu = force_hiz ? '0 : nxt_st.pe_pul & ~(nxt_st.pe_dir & ~nxt_st.pe_lat);
      nxt_st.p8_in = p8_blk;
      nxt_st.pe_in = pe_blk;
      nxt_st.irq = pe_blk;
      nxt_st.trig = st_ff.trgsel ? port1_pin3 : p8_blk[NPINS-1];
   end

   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.p8_lat <= QBGP_RST_LATCH;
         st_ff.pe_lat <= QBGP_RST_LATCH;
         st_ff.p8_dir <= QBGP_RST_DIR;
         st_ff.pe_dir <= QBGP_RST_DIR;
         st_ff.p8_pul <= QBGP_RST_PULL;
         st_ff.pe_pul <= QBGP_RST_PULL;
         st_ff.standby_pin_state_bit <= QBGP_RST_SPL;
         st_ff.trgsel <= QBGP_RST_TRGSEL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register, with hresp tied low
   assign hrdata = {{(32-NPINS){1'b0}}, st_ff.rdata};
   assign hreadyout = st_ff.ready;
   assign hresp = 1'b0;
   assign port8_pin_out = st_ff.p8_out;
   assign port8_pin_oe = st_ff.p8_oe;
   assign port8_pullup_on = st_ff.p8_pu;
   assign porte_pin_out = st_ff.pe_out;
   assign porte_pin_oe = st_ff.pe_oe;
   assign porte_pullup_on = st_ff.pe_pu;
   assign port8_in_path = st_ff.p8_in;
   assign porte_in_path = st_ff.pe_in;
   assign ext_irq_line_a = st_ff.irq[0];
   assign ext_irq_line_b = st_ff.irq[1];
   assign ext_irq_line_c = st_ff.irq[2];
   assign ext_irq_line_d = st_ff.irq[3];
   // Both triggers share one routed source
   assign pwm_timer_trigger_in = st_ff.trig;
   assign adc_trigger_in = st_ff.trig;

   // Checks on observable behaviour
   // All checks share the one clock and the one reset, so they take defaults
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Direction bit set means the pin is driven from the same edge that stores the bit
   a_dir_drives_oe: assert property (!force_hiz |=> port8_pin_oe == $past(nxt_st.p8_dir))
      else $error("port 8 enable does not follow direction");

   // A cleared direction bit must never enable the driver
   a_input_no_drive: assert property (st_ff.pe_dir == '0 && !st_ff.wr_pend |=> porte_pin_oe == '0)
      else $error("input pin driven");

   // The pin value is always the latch, driven or not
   a_out_is_latch: assert property (porte_pin_out == st_ff.pe_lat)
      else $error("port E pin value differs from latch");

   // A latch write shows on the pin at the edge that stores it
   a_write_to_pin: assert property (st_ff.wr_pend && st_ff.wr_idx == QBGP_IDX_P8_LATCH
      |=> port8_pin_out == $past(hwdata[NPINS-1:0]))
      else $error("latch write did not reach pin");

   // Writing the latch of an input pin must not start driving it
   a_latch_no_drive: assert property (st_ff.wr_pend && st_ff.wr_idx == QBGP_IDX_PE_LATCH
      && st_ff.pe_dir == '0 |=> porte_pin_oe == '0)
      else $error("latch write drove an input pin");

   // All-output port reads back its latch on a normal read
   a_read_out_latch: assert property (addr_phase && !hwrite && !rmw_view
      && aidx == QBGP_IDX_PE_LATCH && nxt_st.pe_dir == '1
      |=> hrdata[NPINS-1:0] == $past(nxt_st.pe_lat))
      else $error("output read did not return latch");

   // READ_MODIFY_WRITE_ACCESS view ignores pin levels whatever the direction
   a_rmw_latch_read: assert property (addr_phase && !hwrite && rmw_view
      && aidx == QBGP_IDX_PE_LATCH |=> hrdata[NPINS-1:0] == $past(nxt_st.pe_lat))
      else $error("rmw read returned pins");

   // All-input port reads back the pins while they are not blocked
   a_read_pin_level: assert property (addr_phase && !hwrite && !rmw_view
      && aidx == QBGP_IDX_P8_LATCH && nxt_st.p8_dir == '0 && !force_hiz
      |=> hrdata[NPINS-1:0] == $past(port8_pin_in))
      else $error("input read wrong");

   // Out of reset no pin may be driven
   a_reset_inputs: assert property ($rose(hreadyout) |-> port8_pin_oe == '0
      && porte_pin_oe == '0)
      else $error("pin driven right after reset");

   // Forced standby releases every driver
   a_standby_hiz: assert property (force_hiz ##1 force_hiz |-> port8_pin_oe == '0
      && porte_pin_oe == '0)
      else $error("pin driven in standby");

   // Blocked inputs sit low so a floating pin cannot leak
   a_block_low: assert property (force_hiz && porte_irq_en == '0
      |=> porte_in_path == '0 && port8_in_path[2:0] == 3'h0)
      else $error("blocked input not low");

   // Port 8 pin 3 stays live when its interrupt is enabled both ways
   a_p8_keep_live: assert property (force_hiz && ext_irq_ctrl_ch0_en && irq_pin_select_ctrl_en
      |=> port8_in_path[NPINS-1] == $past(port8_pin_in[NPINS-1]))
      else $error("port 8 pin 3 blocked with interrupt enabled");

   // A port E input with its interrupt enabled stays live
   a_pe_keep_live: assert property (force_hiz && porte_irq_en[0]
      |=> porte_in_path[0] == $past(porte_pin_in[0]))
      else $error("port E input blocked with interrupt enabled");

   // With the pin-state bit clear, standby leaves drive and level alone
   a_keep_state: assert property (standby_stop_watch && !st_ff.standby_pin_state_bit && !st_ff.wr_pend
      |=> port8_pin_oe == $past(st_ff.p8_dir) && port8_pin_out == $past(st_ff.p8_lat))
      else $error("pin state changed in standby");

   // Pull-up bit connects the pull-up on an undriven pin
   a_pullup_on: assert property (!force_hiz && !st_ff.wr_pend && st_ff.pe_pul[1]
      && !st_ff.pe_dir[1] |=> porte_pullup_on[1])
      else $error("pull-up not connected");

   // Driving low always wins over the pull-up bit
   a_pullup_low_off: assert property (port8_pin_oe[0] && !port8_pin_out[0]
      |-> !port8_pullup_on[0])
      else $error("pull-up on while low");

   // Interrupt line follows the pin one edge later
   a_irq_follow: assert property (!force_hiz |=> ext_irq_line_a == $past(porte_pin_in[0]))
      else $error("irq line not following pin");

   // Bit n of a direction write lands on pin n
   a_bit_map: assert property (st_ff.wr_pend && st_ff.wr_idx == QBGP_IDX_P8_DIR && !force_hiz
      |=> port8_pin_oe == $past(hwdata[NPINS-1:0]))
      else $error("direction bits mapped to wrong pins");

   // Alternate trigger source selected
   a_trig_route: assert property (st_ff.trgsel |=> pwm_timer_trigger_in == $past(port1_pin3))
      else $error("trigger routing wrong");

   // Default trigger source is the gated port 8 pin 3
   a_trig_p8: assert property (!st_ff.trgsel |=> adc_trigger_in == $past(p8_blk[NPINS-1]))
      else $error("default trigger routing wrong");

   // Read data never carries anything above the port width
   a_high_bits_zero: assert property (hrdata[31:NPINS] == '0)
      else $error("upper bits nonzero");

   // A write to an unmapped offset changes no register
   a_unmapped_write: assert property (st_ff.wr_pend && st_ff.wr_idx == QBGP_IDX_NONE
      |=> $stable(st_ff.p8_lat) && $stable(st_ff.p8_dir) && $stable(st_ff.pe_lat))
      else $error("unmapped write changed a register");

   // Main scenarios worth seeing at least once
   c_write_dir: cover property (st_ff.wr_pend && st_ff.wr_idx == QBGP_IDX_PE_DIR);
   c_standby_keep: cover property (force_hiz && p8_keep[NPINS-1] && port8_pin_in[NPINS-1]);
   c_rmw_read: cover property (addr_phase && !hwrite && rmw_view);
   // Read issued in the data phase of a write relies on the nxt_st forwarding
   c_read_after_write: cover property (st_ff.wr_pend && addr_phase && !hwrite);
   c_trig_alt: cover property (st_ff.trgsel && port1_pin3);
endmodule

// ---- qbgp_pin_model.sv ----
// Behavioural model of four external pins with pull-ups and an outside driver
`timescale 1ns/1ps
module qbgp_pin_model (
   input wire logic sys_clk,
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] pullup_on,
   input wire logic [3:0] ext_val,
   input wire logic ext_on,
   output logic [3:0] pin_lvl
);
   logic [3:0] last_ff;

   // Remember the last level so a floating pin can wander away from it
   always_ff @(posedge sys_clk) begin
      last_ff <= pin_lvl;
   end

   // The device wins where it drives; the outside driver steps back there
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (pin_oe[i]) begin
            pin_lvl[i] = pin_out[i];
         end else if (ext_on) begin
            pin_lvl[i] = ext_val[i];
         end else if (pullup_on[i]) begin
            pin_lvl[i] = 1'b1;
         end else begin
            pin_lvl[i] = ~last_ff[i]; // Open pin: never trust a stale level
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the quad-bit GPIO ports
`timescale 1ns/1ps
module tb_top;
   import qbgp_pkg::*;
   logic sys_clk, resetn, hsel, hwrite, hreadyout, hresp, sbw, ch0_en, sel_en, p1_pin3;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] pe_irq_en, pout [2], poe [2], ppu [2], lvl [2], ext [2], p8_path, pe_path;
   logic irq_a, irq_b, irq_c, irq_d, trg_pwm, trg_adc, ext_on;
   int mismatches, total_checks;

   qbgp_ports dut_u (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .standby_stop_watch(sbw),
      .ext_irq_ctrl_ch0_en(ch0_en), .irq_pin_select_ctrl_en(sel_en), .porte_irq_en(pe_irq_en),
      .port1_pin3(p1_pin3), .port8_pin_in(lvl[0]), .port8_pin_out(pout[0]),
      .port8_pin_oe(poe[0]), .port8_pullup_on(ppu[0]), .porte_pin_in(lvl[1]),
      .porte_pin_out(pout[1]), .porte_pin_oe(poe[1]), .porte_pullup_on(ppu[1]),
      .port8_in_path(p8_path), .porte_in_path(pe_path), .ext_irq_line_a(irq_a),
      .ext_irq_line_b(irq_b), .ext_irq_line_c(irq_c), .ext_irq_line_d(irq_d),
      .pwm_timer_trigger_in(trg_pwm), .adc_trigger_in(trg_adc));

   // One pin model per port
   for (genvar p = 0; p < 2; p++) begin : g_pins
      qbgp_pin_model pins_u (.sys_clk(sys_clk), .pin_out(pout[p]), .pin_oe(poe[p]),
         .pullup_on(ppu[p]), .ext_val(ext[p]), .ext_on(ext_on), .pin_lvl(lvl[p]));
   end

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Single AHB transfer: address phase, then data phase, each held until hready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h0000_0000;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
   endtask

   // Pins change at the edge that stores the registers and input paths one edge later
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #20000;
      mismatches++;
      print_verdict();
   end

   initial begin
      logic [7:0] b;
      {resetn, hsel, hwrite, sbw, ch0_en, sel_en, p1_pin3} = 7'h00;
      {haddr, hwdata, htrans, hsize, pe_irq_en} = {64'h0, 2'b00, 3'b010, 4'h0};
      ext[0] = 4'hA;
      ext[1] = 4'hA;
      ext_on = 1'b1;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rdc(QBGP_OFS_P8_DIR, 32'h0000_0000);
      rdc(QBGP_OFS_PE_DIR, 32'h0000_0000);
      xfer(1'b1, 8'h1C, 32'h0000_000F);
      rdc(8'h1C, 32'h0000_0000);
      rdc(QBGP_OFS_P8_LATCH | QBGP_OFS_RMW_VIEW, 32'h0000_0000);
      chk(hresp, 1'b0);
      rdc(QBGP_OFS_P8_LATCH, 32'h0000_000A);
      $display("reset test done");
      for (int p = 0; p < 2; p++) begin
         b = p ? QBGP_OFS_PE_LATCH : QBGP_OFS_P8_LATCH;
         xfer(1'b1, b, 32'hFFFF_FFF5);
         rdc(b | QBGP_OFS_RMW_VIEW, 32'h0000_0005);
         chk(poe[p], 4'h0);
         xfer(1'b1, b + 8'h04, 32'h0000_0003);
         settle();
         chk(poe[p], 4'h3);
         chk(pout[p], 4'h5);
         rdc(b, 32'h0000_0009);
         rdc(b + 8'h04, 32'h0000_0003);
         xfer(1'b1, b, 32'h0000_0002);
         #1;
         chk(pout[p], 4'h2);
         xfer(1'b1, b + 8'h08, 32'h0000_000F);
         settle();
         chk(ppu[p], 4'hE);
         xfer(1'b1, b + 8'h04, 32'h0000_0000);
         $display("port %0d test done", p);
      end
      ext[1] <= 4'h6;
      ext[0] <= 4'h8;
      settle();
      chk({irq_d, irq_c, irq_b, irq_a}, 4'h6);
      chk({trg_pwm, trg_adc}, 2'b11);
      rdc(QBGP_OFS_P8_LATCH, 32'h0000_0008);
      xfer(1'b1, QBGP_OFS_CFG, 32'h0000_0002);
      settle();
      chk({trg_pwm, trg_adc}, 2'b00);
      p1_pin3 <= 1'b1;
      settle();
      chk({trg_pwm, trg_adc}, 2'b11);
      $display("routing test done");
      xfer(1'b1, QBGP_OFS_P8_DIR, 32'h0000_0003);
      xfer(1'b1, QBGP_OFS_CFG, 32'h0000_0001);
      sbw <= 1'b1;
      ext[1] <= 4'h5;
      settle();
      chk(poe[0], 4'h0);
      chk(p8_path, 4'h0);
      chk(pe_path, 4'h0);
      ch0_en <= 1'b1;
      sel_en <= 1'b1;
      pe_irq_en <= 4'h1;
      settle();
      chk(p8_path, 4'h8);
      chk(pe_path, 4'h1);
      xfer(1'b1, QBGP_OFS_CFG, 32'h0000_0000);
      settle();
      chk(poe[0], 4'h3);
      chk(pout[0], 4'h2);
      $display("standby test done");
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(hreadyout, 1'b0);
      resetn <= 1'b1;
      rdc(QBGP_OFS_P8_DIR, 32'h0000_0000);
      chk(poe[0], 4'h0);
      $display("second reset test done");
      print_verdict();
   end
endmodule
